// ---- common/core_map.vh ----
`ifndef CORE_MAP_VH
`define CORE_MAP_VH

// ----------------------------------------
// instruction phases
// ----------------------------------------
`define PHASE_ONE 2'h0
`define PHASE_TWO 2'h1
`define PHASE_THREE 2'h2
`define PHASE_FOUR 2'h3

// ----------------------------------------
// opcode fields
// ----------------------------------------
`define OP_SECOND 4'hf
`define OP_JUMP_ABS 8'hef
`define OP_MOVE_FF 4'hc
`define OP_BRANCH 5'h1a
`define OP_LOAD_BANK 12'h010
`define OP_LOAD_W 8'h0e
`define OP_STORE_W 7'h37
`define OP_MOVE_F 6'h14
`define OP_TEST_SKIP 7'h33
`define OP_NOP 16'h0000

// ----------------------------------------
// data memory map
// ----------------------------------------
`define BANK_SEL_ADDR 12'hfe0
`define GPR_BANK 4'h0
`define SFR_HALF 5'h1f
`define ACCESS_LOW_BANK 4'h0
`define ACCESS_HIGH_BANK 4'hf
`define EXT_ACCESS_LIMIT 8'h5f

// ----------------------------------------
// reset values
// ----------------------------------------
`define PC_RESET 20'h00000
`define BANK_SEL_RESET 8'h00
`define W_RESET 8'h00

`endif

// ---- hdl/core_fetch_and_bank_addressing.v ----
// Notes on behaviour
// - one cycle per instruction; branches flush, take two
// - program memory byte addressed, words at even addresses
// - pc steps two bytes, bit zero reads zero
// - absolute jump word address loads pc bits 20:1
// - relative branch offset counts whole instruction words
// - second words carry 1111 and twelve literal bits
// - lone 1111 word executes as no operation
// - twelve-bit data address, sixteen banks, bank 0 and upper half of bank 15 built
// - unimplemented data locations read as zero
// - banked address is bank select nibble over operand byte
// - bank select upper nibble ignores writes, reads zero
// - load bank literal writes bank select directly
// - unimplemented bank writes dropped, flags still update
// - file to file move ignores bank select
// - access map: bank 0 low, bank 15 high
// - access bit one banked, zero access map
// - extended set enable changes access bank map
// - four phases per cycle, fetch overlaps execute
// - operand read phase two, destination write phase four
`timescale 1ns/1ps
`include "core_map.vh"

module core_fetch_and_bank_addressing (
    input wire ref_clk,
    input wire rst,
    input wire [15:0] prog_data,
    input wire extended_isa_enable,
    input wire [11:0] index_base,
    output reg [20:0] prog_addr,
    output reg [1:0] phase,
    output reg exec_valid,
    output reg [7:0] bank_select,
    output reg [7:0] work_reg,
    output reg zero_flag,
    output reg [11:0] data_addr
);

// ----------------------------------------
// storage
// ----------------------------------------
reg [7:0] gpr_mem [0:255];
reg [7:0] sfr_mem [0:127];
// data memory keeps its contents across reset

reg [19:0] pc_word;
reg [15:0] fetched;
reg [19:0] fetched_pc;
reg fetch_ok;
reg [15:0] ir;
reg [19:0] ir_pc;
reg [7:0] operand;
reg follow;
reg follow_copy;

// ----------------------------------------
// helpers
// ----------------------------------------
// only bank 0 and the upper half of bank 15 are built
function in_gpr;
    input [11:0] addr;
    begin
        in_gpr = (addr[11:8] == `GPR_BANK);
    end
endfunction

function in_sfr;
    input [11:0] addr;
    begin
        in_sfr = (addr[11:7] == `SFR_HALF);
    end
endfunction

function is_bank_sel;
    input [11:0] addr;
    begin
        is_bank_sel = (addr == `BANK_SEL_ADDR);
    end
endfunction

function is_zero;
    input [7:0] value;
    begin
        is_zero = (value == 8'h00);
    end
endfunction

function [11:0] map_addr;
    input a_bit;
    input [7:0] f;
    input [3:0] bsel;
    input ext;
    input [11:0] base;
    begin
        if (a_bit) begin
            map_addr = {bsel, f};
        end else if (ext && (f <= `EXT_ACCESS_LIMIT)) begin
            map_addr = base + {4'h0, f};
        end else if (f[7]) begin
            map_addr = {`ACCESS_HIGH_BANK, f};
        end else begin
            map_addr = {`ACCESS_LOW_BANK, f};
        end
    end
endfunction

function [7:0] rd_byte;
    input [11:0] addr;
    begin
        if (in_gpr(addr)) begin
            rd_byte = gpr_mem[addr[7:0]];
        end else if (is_bank_sel(addr)) begin
            rd_byte = bank_select;
        end else if (in_sfr(addr)) begin
            rd_byte = sfr_mem[addr[6:0]];
        end else begin
            rd_byte = 8'h00;
        end
    end
endfunction

// ----------------------------------------
// extended set enable synchroniser
// ----------------------------------------
// a change counts only once the second and third stages agree
reg [2:0] ext_sync;
reg ext_enable;

always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
        ext_sync <= 3'h0;
        ext_enable <= 1'b0;
    end else begin
        ext_sync <= {ext_sync[1:0], extended_isa_enable};
        if (ext_sync[1] == ext_sync[2]) begin
            ext_enable <= ext_sync[2];
        end
    end
end

// ----------------------------------------
// decode
// ----------------------------------------
wire q1 = (phase == `PHASE_ONE);
wire q2 = (phase == `PHASE_TWO);
wire q4 = (phase == `PHASE_FOUR);
wire is_second = (ir[15:12] == `OP_SECOND);
wire is_jump = (ir[15:8] == `OP_JUMP_ABS);
wire is_move_ff = (ir[15:12] == `OP_MOVE_FF);
wire is_branch = (ir[15:11] == `OP_BRANCH);
wire is_load_bank = (ir[15:4] == `OP_LOAD_BANK);
wire is_load_w = (ir[15:8] == `OP_LOAD_W);
wire is_store_w = (ir[15:9] == `OP_STORE_W);
wire is_move_f = (ir[15:10] == `OP_MOVE_F);
wire is_test_skip = (ir[15:9] == `OP_TEST_SKIP);

// the access bit is bit 8 of every banked form
wire [11:0] bank_addr;
assign bank_addr = map_addr(ir[8], ir[7:0], bank_select[3:0],
    ext_enable, index_base);

// full 12-bit addresses for the file to file move
wire [11:0] src_addr;
assign src_addr = is_move_ff ? ir[11:0] : bank_addr;
wire [11:0] dst_addr;
assign dst_addr = (is_second && follow_copy) ? ir[11:0] : bank_addr;

// branch offset counts words, sign taken from bit 10
wire [19:0] branch_off;
assign branch_off = {{9{ir[10]}}, ir[10:0]};
wire [19:0] branch_target;
assign branch_target = ir_pc + 20'h00001 + branch_off;

// ----------------------------------------
// destination write
// ----------------------------------------
reg wr_go;
reg [7:0] wr_data;

// only stores, moves with d set and copy second words write
always @* begin
    wr_go = 1'b0;
    wr_data = operand;
    if (q4 && exec_valid) begin
        if (is_store_w) begin
            wr_go = 1'b1;
            wr_data = work_reg;
        end else if (is_move_f && ir[9]) begin
            wr_go = 1'b1;
        end else if (is_second && follow_copy) begin
            wr_go = 1'b1;
        end
    end
end

// unmapped destinations simply fall through
always @(posedge ref_clk) begin
    if (wr_go) begin
        if (in_gpr(dst_addr)) begin
            gpr_mem[dst_addr[7:0]] <= wr_data;
        end else if (in_sfr(dst_addr) && !is_bank_sel(dst_addr)) begin
            sfr_mem[dst_addr[6:0]] <= wr_data;
        end
    end
end

// ----------------------------------------
// bank select register
// ----------------------------------------
// load literal and data writes never meet: a load is no data write
always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
        bank_select <= `BANK_SEL_RESET;
    end else if (q4 && exec_valid && is_load_bank) begin
        bank_select <= {4'h0, ir[3:0]};
    end else if (wr_go && is_bank_sel(dst_addr)) begin
        bank_select <= {4'h0, wr_data[3:0]};
    end
end

// ----------------------------------------
// fetch, pipeline and execute
// ----------------------------------------
// phase one hands the last fetch to execute and starts the next one
// phase two reads the operand; phase four lands results and the new word
always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
        phase <= `PHASE_ONE;
        pc_word <= `PC_RESET;
        prog_addr <= 21'h000000;
        fetched <= `OP_NOP;
        fetched_pc <= `PC_RESET;
        fetch_ok <= 1'b0;
        ir <= `OP_NOP;
        ir_pc <= `PC_RESET;
        exec_valid <= 1'b0;
        operand <= 8'h00;
        follow <= 1'b0;
        follow_copy <= 1'b0;
        work_reg <= `W_RESET;
        zero_flag <= 1'b0;
        data_addr <= 12'h000;
    end else begin
        phase <= phase + 2'h1;
        if (q1) begin
            // latch last fetch, start next one
            prog_addr <= {pc_word, 1'b0};
            pc_word <= pc_word + 20'h00001;
            ir <= fetched;
            ir_pc <= fetched_pc;
            exec_valid <= fetch_ok;
        end
        if (q2 && exec_valid && !is_second) begin
            operand <= rd_byte(src_addr);
            data_addr <= src_addr;
        end
        if (q4) begin
            fetched <= prog_data;
            fetched_pc <= prog_addr[20:1];
            fetch_ok <= 1'b1;
            follow <= 1'b0;
            follow_copy <= 1'b0;
            if (exec_valid) begin
                if (is_jump) begin
                    // second word arrives now; load target at once
                    pc_word <= {prog_data[11:0], ir[7:0]};
                    follow <= 1'b1;
                end else if (is_move_ff) begin
                    // copy lands in the cycle of the second word
                    follow <= 1'b1;
                    follow_copy <= 1'b1;
                end else if (is_branch) begin
                    // word fetched behind the taken branch is dropped
                    pc_word <= branch_target;
                    fetch_ok <= 1'b0;
                end else if (is_test_skip) begin
                    // skipped word is dropped; a lone second word then idles
                    if (is_zero(operand)) begin
                        fetch_ok <= 1'b0;
                    end
                end else if (is_load_w) begin
                    work_reg <= ir[7:0];
                end else if (is_move_f) begin
                    zero_flag <= is_zero(operand);
                    if (!ir[9]) begin
                        work_reg <= operand;
                    end
                end else if (is_second && !follow) begin
                    // lone second word: nothing happens
                    work_reg <= work_reg;
                end
            end
        end
        if (q2 && exec_valid && is_second && follow_copy) begin
            data_addr <= dst_addr;
        end
    end
end

endmodule // core_fetch_and_bank_addressing

// ---- verif/core_fetch_and_bank_addressing_properties.sv ----
`timescale 1ns/1ps
module core_fetch_and_bank_addressing_properties (
    input wire ref_clk,
    input wire rst,
    input wire [15:0] prog_data,
    input wire [20:0] prog_addr,
    input wire [1:0] phase,
    input wire exec_valid,
    input wire [7:0] bank_select,
    input wire [7:0] work_reg,
    input wire zero_flag
);
    reg [15:0] cur;
    reg [15:0] prv;
    reg ev;
    reg [20:0] pa;
    wire p1 = phase == 2'h1;
    wire gj = p1 && ev && prv[15:8] == 8'hef;
    wire br = p1 && ev && prv[15:11] == 5'h1a;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    // words and state of the instruction that just finished executing
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cur <= 16'h0000;
            prv <= 16'h0000;
            ev <= 1'b0;
            pa <= 21'h000000;
        end else if (phase == 2'h3) begin
            cur <= prog_data;
            prv <= cur;
            ev <= exec_valid;
            pa <= prog_addr;
        end
    end
    a_phase_count: assert property (!rst |=> phase == $past(phase) + 2'h1)
        else $error("phase did not advance by one");
    a_pc_even: assert property (prog_addr[0] == 1'b0)
        else $error("fetch address is odd");
    a_fetch_stands: assert property (phase != 2'h0 |=> $stable({prog_addr, exec_valid}))
        else $error("fetch moved outside phase one");
    a_bank_upper: assert property (bank_select[7:4] == 4'h0)
        else $error("bank select upper nibble set");
    a_result_phase: assert property (phase != 2'h3 |=> $stable({work_reg, zero_flag}))
        else $error("result changed outside phase four");
    a_flush_redirect: assert property (p1 && !gj && prog_addr != pa + 21'h2 |-> !exec_valid)
        else $error("redirect without flush");
    a_jump_target: assert property (gj |-> prog_addr == {cur[11:0], prv[7:0], 1'b0})
        else $error("absolute jump target wrong");
    a_branch_target: assert property (br |-> prog_addr == pa + {{9{prv[10]}}, prv[10:0], 1'b0})
        else $error("relative branch target wrong");
    c_jump: cover property (gj);
    c_branch: cover property (br);
    c_flush: cover property (p1 && !exec_valid && pa != 21'h0);
endmodule // core_fetch_and_bank_addressing_properties
bind core_fetch_and_bank_addressing core_fetch_and_bank_addressing_properties chk (.*);

// ---- verif/core_fetch_and_bank_addressing_tb.sv ----
`timescale 1ns/1ps
module core_fetch_and_bank_addressing_tb;
    localparam [319:0] IMG = {160'h0e00_6ee0_0105_6f10_5110_0e3c_6e20_6e85_5020_c020,
        160'hff90_d001_0e77_6710_c510_ff90_0e00_5090_ef28_f000};
    reg ref_clk = 1'b0;
    reg rst = 1'b1;
    reg extended_isa_enable = 1'b0;
    reg [11:0] index_base = 12'h000;
    wire [15:0] prog_data;
    wire [20:0] prog_addr;
    wire [1:0] phase;
    wire exec_valid;
    wire [7:0] bank_select;
    wire [7:0] work_reg;
    wire zero_flag;
    wire [11:0] data_addr;
    integer err_total = 0;
    integer n_tests = 0;
    integer cyc = 0;
    integer i;
    integer pass;
    reg [7:0] lfsr = 8'h60;
    reg [7:0] rk;
    always #25 ref_clk = ~ref_clk;
    core_fetch_and_bank_addressing uut (.ref_clk(ref_clk), .rst(rst), .prog_data(prog_data),
        .extended_isa_enable(extended_isa_enable), .index_base(index_base),
        .prog_addr(prog_addr), .phase(phase), .exec_valid(exec_valid),
        .bank_select(bank_select), .work_reg(work_reg), .zero_flag(zero_flag),
        .data_addr(data_addr));
    prog_mem pm (.prog_addr(prog_addr), .prog_data(prog_data));
    // data address of a banked form with the access bit clear
    function [11:0] exp_access(input ext, input [11:0] base, input [7:0] f);
        if (ext && f <= 8'h5f)
            exp_access = base + {4'h0, f};
        else
            exp_access = {f[7] ? 4'hf : 4'h0, f};
    endfunction
    function [7:0] nxt(input [7:0] v);
        nxt = {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction
    task results;
        begin
            $display("tests %0d mismatches %0d", n_tests, err_total);
            if (err_total == 0 && n_tests > 0)
                $display("[ PASS ]");
            else
                $display("[ FAIL ]");
            $finish;
        end
    endtask
    task check(input [20:0] seen, input [20:0] exp);
        begin
            n_tests = n_tests + 1;
            if (seen !== exp) begin
                err_total = err_total + 1;
                $display("unexpected at %0t: got %h want %h", $time, seen, exp);
            end
        end
    endtask
    // wait until the word at w has finished executing
    task at(input integer w);
        integer k;
        begin
            k = 0;
            while (prog_addr !== 2 * w + 4 && k < 400) begin
                @(posedge ref_clk);
                #1;
                k = k + 1;
            end
            if (k >= 400) check(prog_addr, 2 * w + 4);
        end
    endtask
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            err_total = err_total + 1;
            results;
        end
    end
    initial begin
        for (pass = 0; pass < 2; pass = pass + 1) begin
            @(posedge ref_clk);
            lfsr = nxt(lfsr);
            rk = lfsr;
            lfsr = nxt(lfsr);
            rst <= 1'b1;
            extended_isa_enable <= pass;
            index_base <= {5'h00, lfsr[6:0]};
            for (i = 0; i < 64; i = i + 1)
                pm.mem[i] = (i < 20) ? IMG[319 - 16 * i -: 16] : 16'h0000;
            pm.mem[0] = {8'h0e, rk};
            pm.mem[40] = 16'h0e99;
            pm.mem[41] = 16'hd7ff;
            repeat (16) @(posedge ref_clk);
            rst <= 1'b0;
            at(1); check(bank_select, rk & 8'h0f);
            at(2); check(bank_select, 8'h05);
            at(3); check(data_addr, 12'h510);
            at(4); check(work_reg, 8'h00);
            check(zero_flag, 1'b1);
            at(6); check(data_addr, exp_access(pass[0], index_base, 8'h20));
            at(7); check(data_addr, exp_access(pass[0], index_base, 8'h85));
            at(8); check(work_reg, 8'h3c);
            check(zero_flag, 1'b0);
            at(10); check(data_addr, 12'hf90);
            at(13); check(work_reg, 8'h3c);
            at(17); check(work_reg, 8'h3c);
            at(40); check(work_reg, 8'h99);
            $display("pass %0d done", pass);
        end
        results;
    end
endmodule // core_fetch_and_bank_addressing_tb

// ---- verif/prog_mem.sv ----
`timescale 1ns/1ps
module prog_mem (
    input wire [20:0] prog_addr,
    output wire [15:0] prog_data
);
    reg [15:0] mem [0:63];
    // whole words at even byte addresses, beyond the array reads no operation
    assign prog_data = (prog_addr[20:7] == 14'h0) ? mem[prog_addr[6:1]] : 16'h0000;
endmodule // prog_mem
